// ### rtl/swd_pkg.sv
// shared constants and types for the sleep/wake and watchdog block
package swd_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] INTCTL_OFS = 8'h04;
   localparam logic [7:0] WDTCTL_OFS = 8'h08;
   localparam int EXPIRY_BIT = 4;
   localparam int PD_BIT = 3;
   localparam int GIE_BIT = 7;
   localparam int SOFT_EN_BIT = 0;
   localparam int PERIOD_LSB = 1;
   localparam int PERIOD_MSB = 5;
   localparam logic [4:0] PERIOD_RESET = 5'h0b;
   localparam logic [4:0] PERIOD_MAX = 5'h12;
   localparam logic SOFT_EN_RESET = 1'b0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // ****************************************
   // timing
   // ****************************************
   localparam int LFOSC_KHZ = 31;
   localparam int CLOCK_KHZ = 25000;
   localparam int BASE_PRESCALE = 32;
   localparam int CNT_W = 24;
   localparam int OST_PERIODS = 1024;
   localparam int OST_CYCLES = OST_PERIODS;
   localparam logic [15:0] ISR_VECTOR = 16'h0004;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_SOFT = 2'b01,
      MODE_AWAKE = 2'b10,
      MODE_ALWAYS = 2'b11
   } swd_mode_e;
   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_SLEEP = 2'b01,
      ST_OST = 2'b10,
      ST_RESUME = 2'b11
   } swd_state_e;
   typedef struct packed {
      logic expiry;
      logic powerdown;
   } swd_flags_s;
   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic valid;
   } swd_ahb_s;
endpackage

// ### rtl/swd_sleep_wake.sv
// sleep sequencing, wake handling and watchdog control with AHB-Lite registers
`timescale 1ns/10ps
module swd_sleep_wake #(
   parameter int NUM_IRQ = 4
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sleepExec,
   input wire logic kickWatchdog,
   input wire logic [NUM_IRQ-1:0] irqFlags,
   input wire logic oscFail,
   input wire logic ostRunning,
   input wire logic lowFreqInternalOscillator,
   input wire logic externalResetPinN,
   input wire logic brownoutReset,
   input wire logic poweronReset,
   input wire logic crystalMode,
   input wire logic [1:0] watchdogModeConfig,
   output logic cpuClockEn,
   output logic ioHold,
   output logic deviceReset,
   output logic watchdogReset,
   output logic resumeExec,
   output logic isrCall,
   output logic [15:0] isrVector
);
   // ****************************************
   // declarations
   // ****************************************
   if (NUM_IRQ < 1 || NUM_IRQ > 7) begin : g_check
      $error("NUM_IRQ must be 1 to 7");
   end

   logic [6:0] pinSync;
   logic lfSync;
   logic lfPrev_ff;
   logic lfTick;
   logic extResetSyncN;
   logic borSync;
   logic porSync;
   logic crystalSync;
   logic [1:0] modeSync;
   swd_pkg::swd_mode_e mode_ff;
   swd_pkg::swd_state_e state_ff;
   swd_pkg::swd_state_e nxt_state;
   swd_pkg::swd_flags_s flags_ff;
   swd_pkg::swd_ahb_s ahb_ff;
   logic gie_ff;
   logic [NUM_IRQ-1:0] irqEnable_ff;
   logic [4:0] period_ff;
   logic softEn_ff;
   logic [31:0] hrdata_ff;
   logic [$clog2(swd_pkg::OST_CYCLES)-1:0] ostCnt_ff;
   logic wokeByIrq_ff;
   logic cpuClockEn_ff;
   logic ioHold_ff;
   logic watchdogReset_ff;
   logic resumeExec_ff;
   logic isrCall_ff;
   logic pendingIrq;
   logic sleeping;
   logic sleepEnter;
   logic sleepNop;
   logic wakeIrq;
   logic wakeWdt;
   logic wake;
   logic ostDone;
   logic wdtActive;
   logic wdtClear;
   logic wdtExpire;
   logic [swd_pkg::CNT_W-1:0] wdtCount;
   logic addrPhase;
   logic wrStatus;
   logic wrIntctl;
   logic wrWdtctl;
   logic [10:0] wdtWakeWait_ff;

   // ****************************************
   // pin synchronisers
   // ****************************************
   swd_sync #(
      .WIDTH(7)
   ) u_sync (
      .clock(clock),
      .clkEn(clkEn),
      .asyncIn({lowFreqInternalOscillator, externalResetPinN, brownoutReset, poweronReset,
                crystalMode, watchdogModeConfig}),
      .syncOut(pinSync)
   );
   assign {lfSync, extResetSyncN, borSync, porSync, crystalSync, modeSync} = pinSync;

   // watchdog time base is the slow oscillator edge
   always_ff @(posedge clock) begin
      if (!rstn) begin
         lfPrev_ff <= 1'b0;
      end else if (clkEn) begin
         lfPrev_ff <= lfSync;
      end
   end
   assign lfTick = lfSync && !lfPrev_ff;

   // pin, brownout and power resets reset the device, asleep or not
   assign deviceReset = !extResetSyncN || borSync || porSync;

   // configuration word is a strap, caught while reset is held
   always_ff @(posedge clock) begin
      if (!rstn) begin
         mode_ff <= swd_pkg::swd_mode_e'(modeSync);
      end
   end

   // ****************************************
   // ahb-lite slave
   // ****************************************
   assign addrPhase = hsel && htrans[1] && hready;
   assign wrStatus = ahb_ff.valid && ahb_ff.write && ahb_ff.addr == swd_pkg::STATUS_OFS;
   assign wrIntctl = ahb_ff.valid && ahb_ff.write && ahb_ff.addr == swd_pkg::INTCTL_OFS;
   assign wrWdtctl = ahb_ff.valid && ahb_ff.write && ahb_ff.addr == swd_pkg::WDTCTL_OFS;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_ff;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ahb_ff <= '0;
         hrdata_ff <= swd_pkg::RD_ZERO;
      end else if (clkEn) begin
         ahb_ff.valid <= addrPhase;
         ahb_ff.write <= hwrite;
         ahb_ff.addr <= haddr[7:0];
         hrdata_ff <= swd_pkg::RD_ZERO;
         if (addrPhase && !hwrite) begin
            case (haddr[7:0])
               swd_pkg::STATUS_OFS: begin
                  hrdata_ff[swd_pkg::EXPIRY_BIT] <= flags_ff.expiry;
                  hrdata_ff[swd_pkg::PD_BIT] <= flags_ff.powerdown;
               end
               swd_pkg::INTCTL_OFS: begin
                  hrdata_ff[swd_pkg::GIE_BIT] <= gie_ff;
                  hrdata_ff[NUM_IRQ-1:0] <= irqEnable_ff;
               end
               swd_pkg::WDTCTL_OFS: begin
                  hrdata_ff[swd_pkg::PERIOD_MSB:swd_pkg::PERIOD_LSB] <= period_ff;
                  hrdata_ff[swd_pkg::SOFT_EN_BIT] <= softEn_ff;
               end
               default: begin
                  hrdata_ff <= swd_pkg::RD_ZERO;
               end
            endcase
         end
      end
   end

   // interrupt control register
   always_ff @(posedge clock) begin
      if (!rstn) begin
         gie_ff <= 1'b0;
         irqEnable_ff <= '0;
      end else if (clkEn && wrIntctl) begin
         gie_ff <= hwdata[swd_pkg::GIE_BIT];
         irqEnable_ff <= hwdata[NUM_IRQ-1:0];
      end
   end

   // period defaults to two seconds after rstn, pin, brownout or power reset; a watchdog reset leaves it
   always_ff @(posedge clock) begin
      if (!rstn || deviceReset) begin
         period_ff <= swd_pkg::PERIOD_RESET;
         softEn_ff <= swd_pkg::SOFT_EN_RESET;
      end else if (clkEn && wrWdtctl) begin
         // period in bits 5:1, enable in bit 0
         period_ff <= hwdata[swd_pkg::PERIOD_MSB:swd_pkg::PERIOD_LSB];
         softEn_ff <= hwdata[swd_pkg::SOFT_EN_BIT];
      end
   end

   // ****************************************
   // sleep and wake sequencing
   // ****************************************
   // only the source's own enable matters for wake
   assign pendingIrq = |(irqFlags & irqEnable_ff);
   assign sleeping = state_ff == swd_pkg::ST_SLEEP;
   // a pending enabled interrupt turns sleep into a no-op
   assign sleepNop = state_ff == swd_pkg::ST_AWAKE && sleepExec && pendingIrq;
   assign sleepEnter = state_ff == swd_pkg::ST_AWAKE && sleepExec && !pendingIrq
                       && !deviceReset;
   // an interrupt arriving during sleep wakes at once
   assign wakeIrq = sleeping && pendingIrq;
   // expiry in sleep wakes instead of resetting
   assign wakeWdt = sleeping && wdtExpire && !pendingIrq;
   assign wake = (wakeIrq || wakeWdt) && !deviceReset;
   assign ostDone = ostCnt_ff == ($clog2(swd_pkg::OST_CYCLES))'(swd_pkg::OST_CYCLES - 1);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         swd_pkg::ST_AWAKE: begin
            if (sleepEnter) begin
               nxt_state = swd_pkg::ST_SLEEP;
            end
         end
         swd_pkg::ST_SLEEP: begin
            // crystal modes wait out the startup delay
            if (wake) begin
               nxt_state = crystalSync ? swd_pkg::ST_OST : swd_pkg::ST_RESUME;
            end
         end
         swd_pkg::ST_OST: begin
            if (ostDone) begin
               nxt_state = swd_pkg::ST_RESUME;
            end
         end
         swd_pkg::ST_RESUME: begin
            nxt_state = swd_pkg::ST_AWAKE;
         end
         default: begin
            nxt_state = swd_pkg::ST_AWAKE;
         end
      endcase
      if (deviceReset) begin
         nxt_state = swd_pkg::ST_AWAKE;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_ff <= swd_pkg::ST_AWAKE;
      end else if (clkEn) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         ostCnt_ff <= '0;
      end else if (clkEn) begin
         ostCnt_ff <= (state_ff == swd_pkg::ST_OST) ? ostCnt_ff + 1'b1 : '0;
      end
   end

   // cpu clock off from sleep until resume; slow oscillator untouched
   // pins held in their pre-sleep drive state over the same span
   always_ff @(posedge clock) begin
      if (!rstn) begin
         cpuClockEn_ff <= 1'b1;
         ioHold_ff <= 1'b0;
      end else if (clkEn) begin
         cpuClockEn_ff <= nxt_state == swd_pkg::ST_AWAKE || nxt_state == swd_pkg::ST_RESUME;
         ioHold_ff <= nxt_state == swd_pkg::ST_SLEEP || nxt_state == swd_pkg::ST_OST;
      end
   end
   assign cpuClockEn = cpuClockEn_ff;
   assign ioHold = ioHold_ff;

   // cpu runs the prefetched instruction, then calls only with global enable
   // the call target is the fixed vector
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wokeByIrq_ff <= 1'b0;
         resumeExec_ff <= 1'b0;
         isrCall_ff <= 1'b0;
      end else if (clkEn) begin
         if (wake) begin
            wokeByIrq_ff <= wakeIrq;
         end
         resumeExec_ff <= state_ff == swd_pkg::ST_RESUME;
         isrCall_ff <= state_ff == swd_pkg::ST_RESUME && wokeByIrq_ff && gie_ff;
      end
   end
   assign resumeExec = resumeExec_ff;
   assign isrCall = isrCall_ff;
   assign isrVector = swd_pkg::ISR_VECTOR;

   // ****************************************
   // status flags
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rstn || deviceReset) begin
         flags_ff <= '{expiry: 1'b1, powerdown: 1'b1};
      end else if (clkEn) begin
         if (state_ff == swd_pkg::ST_AWAKE && wdtExpire) begin
            flags_ff <= '{expiry: 1'b0, powerdown: 1'b1};
         // sleep entry clears powerdown and sets expiry
         end else if (sleepEnter) begin
            flags_ff <= '{expiry: 1'b1, powerdown: 1'b0};
         // interrupt wake keeps the sleep record
         end else if (wakeIrq) begin
            flags_ff <= '{expiry: 1'b1, powerdown: 1'b0};
         end else if (wakeWdt) begin
            flags_ff <= '{expiry: 1'b0, powerdown: 1'b0};
         end else if (kickWatchdog && state_ff == swd_pkg::ST_AWAKE) begin
            flags_ff <= '{expiry: 1'b1, powerdown: 1'b1};
         end
      end
   end

   // ****************************************
   // watchdog
   // ****************************************
   // mode 11 always active
   // mode 01 follows the software enable alone
   always_comb begin
      case (mode_ff)
         swd_pkg::MODE_ALWAYS: wdtActive = 1'b1;
         swd_pkg::MODE_AWAKE: wdtActive = !sleeping;
         swd_pkg::MODE_SOFT: wdtActive = softEn_ff;
         default: wdtActive = 1'b0;
      endcase
   end

   // sleep entry clears, counting resumes if active in sleep
   // resets, kick, oscillator fail and startup timer clear
   // held clear through the crystal startup wait
   // counter sees only slow ticks, so divider changes cannot disturb it
   assign wdtClear = !wdtActive || deviceReset || watchdogReset_ff || sleepEnter || wake
                     || (kickWatchdog && state_ff == swd_pkg::ST_AWAKE) || oscFail
                     || ostRunning || state_ff == swd_pkg::ST_OST;

   swd_wdt_counter u_wdt (
      .clock(clock),
      .rstn(rstn),
      .clkEn(clkEn),
      .tick(lfTick),
      .clear(wdtClear),
      .periodSel(period_ff),
      .expire(wdtExpire),
      .count(wdtCount)
   );

   // expiry while awake resets the device
   always_ff @(posedge clock) begin
      if (!rstn) begin
         watchdogReset_ff <= 1'b0;
      end else if (clkEn) begin
         watchdogReset_ff <= state_ff == swd_pkg::ST_AWAKE && wdtExpire && !deviceReset;
      end
   end
   assign watchdogReset = watchdogReset_ff;

   // ****************************************
   // assertions
   // ****************************************
   a_sleep_flags: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      sleepEnter |=> !flags_ff.powerdown && flags_ff.expiry && sleeping)
      else $error("sleep entry did not update flags");
   a_sleep_noop: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      sleepNop && !deviceReset && !wdtExpire && !kickWatchdog |=> $stable(flags_ff)
      && state_ff == swd_pkg::ST_AWAKE)
      else $error("sleep with pending interrupt was not a no-op");
   a_clock_gated: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      sleeping |-> !cpuClockEn && ioHold)
      else $error("cpu clock running or pins free in sleep");
   a_irq_wake: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      wakeIrq && !deviceReset |=> state_ff inside {swd_pkg::ST_OST, swd_pkg::ST_RESUME}
      && wdtCount == '0)
      else $error("interrupt did not wake device");
   a_wake_clear: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      wake |=> wdtCount == '0)
      else $error("watchdog not cleared on wake");
   a_awake_reset: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      state_ff == swd_pkg::ST_AWAKE && wdtExpire && !deviceReset |=> watchdogReset
      && !flags_ff.expiry)
      else $error("awake expiry gave no reset");
   // cycles from an expiry wake until resume
   // counted here because the crystal wait is too long for a delay range
   always_ff @(posedge clock) begin
      if (!rstn || deviceReset) begin
         wdtWakeWait_ff <= '0;
      end else if (clkEn) begin
         if (resumeExec_ff) begin
            wdtWakeWait_ff <= '0;
         end else if (wakeWdt) begin
            wdtWakeWait_ff <= 11'h001;
         end else if (wdtWakeWait_ff != '0) begin
            wdtWakeWait_ff <= wdtWakeWait_ff + 11'h001;
         end
      end
   end
   a_sleep_expire: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      wakeWdt && !deviceReset |=> !watchdogReset)
      else $error("sleep expiry caused a reset");
   a_expire_resume: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      wdtWakeWait_ff <= 11'h406)
      else $error("sleep expiry did not resume");
   a_ost_hold: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      state_ff == swd_pkg::ST_OST && $past(state_ff) == swd_pkg::ST_OST |-> wdtCount == '0)
      else $error("watchdog counted during startup wait");
   a_mode_off: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      mode_ff == swd_pkg::MODE_OFF |=> wdtCount == '0 && !wdtExpire)
      else $error("disabled watchdog counted");
   a_isr_vector: assert property (@(posedge clock) disable iff (!rstn || !clkEn)
      isrCall |-> resumeExec && gie_ff && isrVector == swd_pkg::ISR_VECTOR)
      else $error("interrupt call without resume or enable");
endmodule

// ### rtl/swd_sync.sv
// two-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/10ps
module swd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic clkEn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   // no reset: strap levels must flow through while reset is held
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge clock) begin
         if (clkEn) begin
            meta_ff <= asyncIn[i];
            sync_ff <= meta_ff;
         end
      end
      assign syncOut[i] = sync_ff;
   end
endmodule

// ### rtl/swd_wdt_counter.sv
// watchdog prescale counter on slow oscillator ticks
`timescale 1ns/10ps
module swd_wdt_counter (
   input wire logic clock,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic tick,
   input wire logic clear,
   input wire logic [4:0] periodSel,
   output logic expire,
   output logic [swd_pkg::CNT_W-1:0] count
);
   logic [swd_pkg::CNT_W-1:0] count_ff;
   logic expire_ff;
   logic [swd_pkg::CNT_W-1:0] limit;
   logic [swd_pkg::CNT_W-1:0] nxt_count;

   // ****************************************
   // period decode
   // ****************************************
   // 32 times two to n, reserved gives 1:32
   always_comb begin
      if (periodSel > swd_pkg::PERIOD_MAX) begin
         limit = swd_pkg::CNT_W'(swd_pkg::BASE_PRESCALE);
      end else begin
         limit = swd_pkg::CNT_W'(swd_pkg::BASE_PRESCALE) << periodSel;
      end
      nxt_count = count_ff + 1'b1;
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         count_ff <= '0;
         expire_ff <= 1'b0;
      end else if (clkEn) begin
         expire_ff <= 1'b0;
         if (clear) begin
            count_ff <= '0;
         end else if (tick) begin
            if (nxt_count == limit) begin
               count_ff <= '0;
               expire_ff <= 1'b1;
            end else begin
               count_ff <= nxt_count;
            end
         end
      end
   end
   assign expire = expire_ff;
   assign count = count_ff;
endmodule

// ### verif/swd_cpu_model.sv
// core model that issues sleep and watchdog-clear instructions
`timescale 1ns/10ps
module swd_cpu_model (
   input wire logic clock,
   input wire logic cpuClockEn,
   output logic sleepExec,
   output logic kickWatchdog
);
   // ****************************************
   // instruction issue
   // ****************************************
   initial begin
      sleepExec = 1'b0;
      kickWatchdog = 1'b0;
   end
   // gated cpu clock
   // the core issues nothing while its clock is stopped
   task automatic issue(input bit isSleep);
      @(posedge clock);
      while (cpuClockEn !== 1'b1) @(posedge clock);
      if (isSleep) begin
         sleepExec <= 1'b1;
      end else begin
         kickWatchdog <= 1'b1;
      end
      @(posedge clock);
      // no_operation after sleep
      // the prefetched slot is a no_operation, so nothing more is issued
      sleepExec <= 1'b0;
      kickWatchdog <= 1'b0;
   endtask
endmodule

// ### verif/swd_testbench.sv
// self-checking bench for the sleep/wake and watchdog block
`timescale 1ns/10ps
module testbench;
   logic clock = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, modeCfg = 2'h1;
   logic [3:0] irqFlags = 4'h0;
   logic lfOsc = 1'b0, extRstN = 1'b1, crystal = 1'b0, oscFail = 1'b0;
   logic ostRun = 1'b0, bor = 1'b0, por = 1'b0, clkEn = 1'b1;
   logic hreadyout, hresp, sleepExec, kickWd, cpuClockEn, ioHold, deviceReset;
   logic watchdogReset, resumeExec, isrCall;
   logic [15:0] isrVector;
   int bad_count = 0, samples_checked = 0, cycles = 0, wdRst = 0;
   localparam logic [7:0] ST = swd_pkg::STATUS_OFS;
   localparam logic [7:0] IC = swd_pkg::INTCTL_OFS;
   localparam logic [7:0] WC = swd_pkg::WDTCTL_OFS;

   swd_sleep_wake dut (.clock(clock), .rstn(rstn), .clkEn(clkEn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .sleepExec(sleepExec), .kickWatchdog(kickWd), .irqFlags(irqFlags),
      .oscFail(oscFail), .ostRunning(ostRun), .lowFreqInternalOscillator(lfOsc),
      .externalResetPinN(extRstN), .brownoutReset(bor), .poweronReset(por),
      .crystalMode(crystal), .watchdogModeConfig(modeCfg), .cpuClockEn(cpuClockEn),
      .ioHold(ioHold), .deviceReset(deviceReset), .watchdogReset(watchdogReset),
      .resumeExec(resumeExec), .isrCall(isrCall), .isrVector(isrVector));
   swd_cpu_model cpu (.clock(clock), .cpuClockEn(cpuClockEn), .sleepExec(sleepExec),
      .kickWatchdog(kickWd));

   // ****************************************
   // clocks, sampling and tasks
   // ****************************************
   initial forever #20 clock = ~clock;
   // slow oscillator sped up so long periods fit the run
   initial forever #160 lfOsc = ~lfOsc;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (watchdogReset === 1'b1) wdRst <= wdRst + 1;
      if (cycles == 20000) begin
         $display("BAD %0t timeout", $time);
         bad_count = bad_count + 1;
         tally_and_finish();
      end
   end
   function automatic logic [31:0] st(input logic e, input logic p);
      return (32'(e) << swd_pkg::EXPIRY_BIT) | (32'(p) << swd_pkg::PD_BIT);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(q, exp, what);
   endtask
   // returns the wait length; equal to lim means the event did not come within lim - 1 cycles
   task automatic waitEv(input bit wd, input int lim, output int n);
      n = 0;
      do begin
         @(posedge clock);
         n = n + 1;
      end while (n < lim && (wd ? watchdogReset : resumeExec) !== 1'b1);
   endtask
   task automatic rst(input logic [1:0] m);
      @(posedge clock);
      modeCfg <= m;
      rstn <= 1'b0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      int n, w;
      rst(2'h1);
      rdc(ST, st(1'b1, 1'b1), "status reset");
      rdc(WC, 32'h16, "period reset");
      wr(WC, 32'hff);
      rdc(WC, 32'h3f, "control fields");
      rdc(8'h0c, 32'h0, "unmapped read");
      wr(ST, 32'h0);
      rdc(ST, st(1'b1, 1'b1), "status write ignored");
      wr(WC, 32'h0);
      clkEn <= 1'b0;
      wr(WC, 32'h3f);
      clkEn <= 1'b1;
      rdc(WC, 32'h0, "frozen write");
      chk(hresp, 1'b0, "okay response");
      wr(IC, 32'h1);
      $display("test registers done");
      irqFlags <= 4'h1;
      cpu.issue(1'b1);
      repeat (3) @(posedge clock);
      chk(cpuClockEn, 1'b1, "pending irq sleep");
      rdc(ST, st(1'b1, 1'b1), "no-op flags");
      irqFlags <= 4'h0;
      $display("test no-op sleep done");
      cpu.issue(1'b1);
      repeat (3) @(posedge clock);
      chk({cpuClockEn, ioHold}, 2'b01, "asleep outputs");
      rdc(ST, st(1'b1, 1'b0), "sleep flags");
      irqFlags <= 4'h2;
      repeat (50) @(posedge clock);
      chk(cpuClockEn, 1'b0, "masked source");
      irqFlags <= 4'h1;
      waitEv(1'b0, 50, n);
      chk({n < 50, isrCall}, 2'b10, "wake without global enable");
      rdc(ST, st(1'b1, 1'b0), "irq wake flags");
      chk(ioHold, 1'b0, "pins released");
      irqFlags <= 4'h0;
      wr(IC, 32'h81);
      crystal <= 1'b1;
      cpu.issue(1'b1);
      irqFlags <= 4'h1;
      waitEv(1'b0, 1200, n);
      chk({n >= 1024, n < 1200, isrCall, isrVector}, 19'h70004, "crystal isr");
      irqFlags <= 4'h0;
      crystal <= 1'b0;
      wr(IC, 32'h0);
      $display("test sleep wake done");
      wr(WC, 32'h1);
      w = wdRst;
      oscFail <= 1'b1;
      repeat (300) @(posedge clock);
      oscFail <= 1'b0;
      ostRun <= 1'b1;
      repeat (300) @(posedge clock);
      ostRun <= 1'b0;
      repeat (8) begin
         repeat (100) @(posedge clock);
         cpu.issue(1'b0);
      end
      chk(32'(wdRst - w), 32'h0, "cleared watchdog");
      waitEv(1'b1, 400, n);
      chk(n < 400, 1'b1, "awake expiry");
      rdc(ST, st(1'b0, 1'b1), "expiry flags");
      w = wdRst;
      cpu.issue(1'b1);
      waitEv(1'b0, 400, n);
      chk({n > 240, n < 400}, 2'b11, "sleep expiry wake");
      chk(32'(wdRst - w), 32'h0, "no reset in sleep");
      rdc(ST, st(1'b0, 1'b0), "sleep expiry flags");
      wr(WC, 32'h0);
      $display("test watchdog done");
      for (int m = 0; m < 4; m++) begin
         rst(2'(m));
         wr(WC, 32'h0);
         waitEv(1'b1, 400, n);
         chk(n < 400, m >= 2, "awake mode");
         cpu.issue(1'b1);
         waitEv(1'b0, 400, n);
         chk(n < 400, m == 3, "sleep mode");
      end
      $display("test modes done");
      for (int s = 0; s < 3; s++) begin
         {por, bor, extRstN} <= 3'b001 ^ 3'(1 << s);
         repeat (4) @(posedge clock);
         chk(deviceReset, 1'b1, "pin reset");
         {por, bor, extRstN} <= 3'b001;
         repeat (4) @(posedge clock);
         chk(deviceReset, 1'b0, "pin released");
      end
      $display("test pin reset done");
      tally_and_finish();
   end
endmodule
